// File: logic/drsc_map.svh
// register offsets, field positions, reset values and bus responses of the session control block
`ifndef DRSC_MAP_SVH
`define DRSC_MAP_SVH

// register byte offsets
`define DRSC_OFF_CTRL_STS 12'h000
`define DRSC_OFF_EVT_FLAGS 12'h004
`define DRSC_OFF_BUS_CFG 12'h008
`define DRSC_OFF_LINK_CFG 12'h00C
`define DRSC_OFF_RST_CTRL 12'h010
`define DRSC_OFF_CORE_INT 12'h014
`define DRSC_OFF_CORE_MASK 12'h018
`define DRSC_OFF_RX_PEEK 12'h01C
`define DRSC_OFF_RX_POP 12'h020
`define DRSC_OFF_RX_SIZE 12'h024
`define DRSC_OFF_NPTX_CFG 12'h028
`define DRSC_OFF_NPTX_STS 12'h02C
`define DRSC_OFF_GEN_CFG 12'h038
`define DRSC_OFF_CORE_ID 12'h03C
`define DRSC_OFF_HPTX_SIZE 12'h100
`define DRSC_OFF_INEP1_SIZE 12'h104
`define DRSC_OFF_INEP2_SIZE 12'h108
`define DRSC_OFF_INEP3_SIZE 12'h10C
`define DRSC_OFF_EVT_MASK 12'h040
`define DRSC_OFF_ROLE_CFG 12'h044

// control/status bit positions
`define DRSC_BIT_SESSION_REQ_OK 0
`define DRSC_BIT_SESSION_REQ 1
`define DRSC_BIT_SWAP_OK 8
`define DRSC_BIT_SWAP_REQ 9
`define DRSC_BIT_HOST_SWAP_EN 10
`define DRSC_BIT_DEV_SWAP_EN 11
`define DRSC_BIT_CONN_ID 16
`define DRSC_BIT_DEBOUNCE 17
`define DRSC_BIT_A_VALID 18
`define DRSC_BIT_B_VALID 19

// event flag bit positions
`define DRSC_BIT_SESSION_REQ_OK_CHG 8
`define DRSC_BIT_SWAP_OK_CHG 9

// role configuration field positions
`define DRSC_BIT_FORCE_HOST 0
`define DRSC_BIT_FORCE_DEV 1
`define DRSC_BIT_LOW_SPEED 2

// reset values and writable masks
`define DRSC_RST_CTRL_STS 32'h0001_0000
`define DRSC_EVT_MASK_BITS 32'h0000_0300
`define DRSC_ZERO 32'h0000_0000

// bus responses
`define DRSC_RESP_OKAY 2'h0
`define DRSC_RESP_SLVERR 2'h2

`endif

// File: logic/drsc_pkg.sv
// types shared by the session control block
package drsc_pkg;

  // role the core presently takes
  typedef enum logic [2:0] {
    DRSC_ROLE_IDLE = 3'b001,
    DRSC_ROLE_DEV = 3'b010,
    DRSC_ROLE_HOST = 3'b100
  } drsc_role_type;

  // line rate selection in host role
  typedef enum logic [1:0] {
    DRSC_SPEED_FULL = 2'b01,
    DRSC_SPEED_LOW = 2'b10
  } drsc_speed_type;

endpackage : drsc_pkg

// File: logic/drsc_session_ctrl.sv
// session and role negotiation control with its AXI4-Lite register file
`timescale 1ns/1ps
`include "drsc_map.svh"

module drsc_session_ctrl
  import drsc_pkg::*;
#(
  parameter bit HOST_CAPABLE = 1'b1,
  parameter bit DEV_CAPABLE = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // session status from the link side
  input wire logic session_req_ok_in,
  input wire logic role_swap_ok_in,
  input wire logic connector_id_in,
  input wire logic debounce_short_in,
  input wire logic a_session_valid_in,
  input wire logic b_session_valid_in,
  // requests toward the link side
  output logic session_req,
  output logic role_swap_req,
  output logic host_side_swap_en,
  output logic dev_side_swap_en,
  output logic host_mode,
  output logic low_speed,
  // interrupt
  output logic irq
);

  // write channel state
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] byte_mask;
  // register state
  logic session_req_ok;
  logic role_swap_ok;
  logic connector_id_state;
  logic debounce_length;
  logic a_session_valid;
  logic b_session_valid;
  logic [1:0] evt_flags;
  logic [1:0] evt_mask;
  logic [2:0] role_cfg;
  logic [31:0] plain_regs [0:11];
  logic [31:0] ctrl_view;
  drsc_role_type role;

  // index of a plain read/write register, or 15 when none
  function automatic logic [3:0] plain_index(input logic [11:0] a);
    logic [3:0] idx;
    idx = 4'hF;
    if (a == `DRSC_OFF_BUS_CFG) idx = 4'h0;
    else if (a == `DRSC_OFF_LINK_CFG) idx = 4'h1;
    else if (a == `DRSC_OFF_RST_CTRL) idx = 4'h2;
    else if (a == `DRSC_OFF_CORE_INT) idx = 4'h3;
    else if (a == `DRSC_OFF_CORE_MASK) idx = 4'h4;
    else if (a == `DRSC_OFF_RX_SIZE) idx = 4'h5;
    else if (a == `DRSC_OFF_NPTX_CFG) idx = 4'h6;
    else if (a == `DRSC_OFF_GEN_CFG) idx = 4'h7;
    else if (a == `DRSC_OFF_HPTX_SIZE) idx = 4'h8;
    else if (a == `DRSC_OFF_INEP1_SIZE) idx = 4'h9;
    else if (a == `DRSC_OFF_INEP2_SIZE) idx = 4'hA;
    else if (a == `DRSC_OFF_INEP3_SIZE) idx = 4'hB;
    return idx;
  endfunction : plain_index

  // true for any mapped offset
  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    hit = (plain_index(a) != 4'hF);
    if (a == `DRSC_OFF_CTRL_STS || a == `DRSC_OFF_EVT_FLAGS) hit = 1'b1;
    else if (a == `DRSC_OFF_RX_PEEK || a == `DRSC_OFF_RX_POP) hit = 1'b1;
    else if (a == `DRSC_OFF_NPTX_STS || a == `DRSC_OFF_CORE_ID) hit = 1'b1;
    else if (a == `DRSC_OFF_EVT_MASK || a == `DRSC_OFF_ROLE_CFG) hit = 1'b1;
    return hit;
  endfunction : is_mapped

  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // write address and data capture, in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, error for unmapped offsets
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DRSC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr) ? `DRSC_RESP_OKAY : `DRSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // status inputs captured into the status view
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      session_req_ok <= 1'b0;
      role_swap_ok <= 1'b0;
      connector_id_state <= 1'b1;
      debounce_length <= 1'b0;
      a_session_valid <= 1'b0;
      b_session_valid <= 1'b0;
    end else begin
      session_req_ok <= (role == DRSC_ROLE_DEV) && session_req_ok_in;
      if (wr_go && aw_addr == `DRSC_OFF_CTRL_STS && w_strb[1] &&
          w_data[`DRSC_BIT_SWAP_REQ]) begin
        role_swap_ok <= 1'b0;
      end else begin
        role_swap_ok <= (role == DRSC_ROLE_DEV) && role_swap_ok_in;
      end
      connector_id_state <= connector_id_in;
      debounce_length <= (role == DRSC_ROLE_HOST) && debounce_short_in;
      a_session_valid <= (role == DRSC_ROLE_HOST) && a_session_valid_in;
      b_session_valid <= (role == DRSC_ROLE_DEV) && b_session_valid_in;
    end
  end

  // role choice from build options, force bits and connector identity
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      role <= DRSC_ROLE_IDLE;
    end else if (HOST_CAPABLE && (!DEV_CAPABLE || role_cfg[`DRSC_BIT_FORCE_HOST])) begin
      role <= DRSC_ROLE_HOST;
    end else if (DEV_CAPABLE && (!HOST_CAPABLE || role_cfg[`DRSC_BIT_FORCE_DEV])) begin
      role <= DRSC_ROLE_DEV;
    end else if (HOST_CAPABLE && DEV_CAPABLE) begin
      role <= connector_id_state ? DRSC_ROLE_DEV : DRSC_ROLE_HOST;
    end else begin
      role <= DRSC_ROLE_IDLE;
    end
  end

  // session and negotiation requests, cleared along with their change flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      session_req <= 1'b0;
      role_swap_req <= 1'b0;
      host_side_swap_en <= 1'b0;
      dev_side_swap_en <= 1'b0;
    end else begin
      if (wr_go && aw_addr == `DRSC_OFF_CTRL_STS && w_strb[0]) begin
        session_req <= w_data[`DRSC_BIT_SESSION_REQ];
      end else if (wr_go && aw_addr == `DRSC_OFF_EVT_FLAGS && w_strb[1] &&
                   w_data[`DRSC_BIT_SESSION_REQ_OK_CHG] && evt_flags[0]) begin
        session_req <= 1'b0;
      end
      if (wr_go && aw_addr == `DRSC_OFF_CTRL_STS && w_strb[1]) begin
        role_swap_req <= w_data[`DRSC_BIT_SWAP_REQ];
        host_side_swap_en <= w_data[`DRSC_BIT_HOST_SWAP_EN];
        dev_side_swap_en <= w_data[`DRSC_BIT_DEV_SWAP_EN];
      end else if (wr_go && aw_addr == `DRSC_OFF_EVT_FLAGS && w_strb[1] &&
                   w_data[`DRSC_BIT_SWAP_OK_CHG] && evt_flags[1]) begin
        role_swap_req <= 1'b0;
      end
    end
  end

  // sticky change flags; a new change beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_flags <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && session_req_ok != ((role == DRSC_ROLE_DEV) && session_req_ok_in)) ||
            (i == 1 && role_swap_ok != ((role == DRSC_ROLE_DEV) && role_swap_ok_in))) begin
          evt_flags[i] <= 1'b1;
        end else if (wr_go && aw_addr == `DRSC_OFF_EVT_FLAGS && w_strb[1] &&
                     w_data[`DRSC_BIT_SESSION_REQ_OK_CHG + i]) begin
          evt_flags[i] <= 1'b0;
        end
      end
    end
  end

  // event mask and role configuration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask <= 2'b00;
      role_cfg <= 3'b000;
    end else if (wr_go && aw_addr == `DRSC_OFF_EVT_MASK && w_strb[1]) begin
      evt_mask <= w_data[`DRSC_BIT_SWAP_OK_CHG:`DRSC_BIT_SESSION_REQ_OK_CHG];
    end else if (wr_go && aw_addr == `DRSC_OFF_ROLE_CFG && w_strb[0]) begin
      role_cfg <= w_data[2:0];
    end
  end

  // line rate: low speed only in host role
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_mode <= 1'b0;
      low_speed <= 1'b0;
    end else begin
      host_mode <= (role == DRSC_ROLE_HOST);
      low_speed <= (role == DRSC_ROLE_HOST) && role_cfg[`DRSC_BIT_LOW_SPEED];
    end
  end

  // interrupt level from unmasked flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_flags & evt_mask);
    end
  end

  // plain read/write registers kept for the rest of the core
  for (genvar g = 0; g < 12; g++) begin : g_plain
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        plain_regs[g] <= `DRSC_ZERO;
      end else if (wr_go && plain_index(aw_addr) == 4'(g)) begin
        plain_regs[g] <= (plain_regs[g] & ~byte_mask) | (w_data & byte_mask);
      end
    end
  end

  // control/status read view, reserved bits zero
  always_comb begin
    ctrl_view = `DRSC_ZERO;
    ctrl_view[`DRSC_BIT_SESSION_REQ_OK] = session_req_ok;
    ctrl_view[`DRSC_BIT_SESSION_REQ] = session_req;
    ctrl_view[`DRSC_BIT_SWAP_OK] = role_swap_ok;
    ctrl_view[`DRSC_BIT_SWAP_REQ] = role_swap_req;
    ctrl_view[`DRSC_BIT_HOST_SWAP_EN] = host_side_swap_en;
    ctrl_view[`DRSC_BIT_DEV_SWAP_EN] = dev_side_swap_en;
    ctrl_view[`DRSC_BIT_CONN_ID] = connector_id_state;
    ctrl_view[`DRSC_BIT_DEBOUNCE] = debounce_length;
    ctrl_view[`DRSC_BIT_A_VALID] = a_session_valid;
    ctrl_view[`DRSC_BIT_B_VALID] = b_session_valid;
  end

  // read channel, one cycle from address to data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `DRSC_ZERO;
      s_axi_rresp <= `DRSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `DRSC_RESP_OKAY : `DRSC_RESP_SLVERR;
        if (s_axi_araddr == `DRSC_OFF_CTRL_STS) begin
          s_axi_rdata <= ctrl_view;
        end else if (s_axi_araddr == `DRSC_OFF_EVT_FLAGS) begin
          s_axi_rdata <= {22'h0, evt_flags, 8'h00};
        end else if (s_axi_araddr == `DRSC_OFF_EVT_MASK) begin
          s_axi_rdata <= {22'h0, evt_mask, 8'h00};
        end else if (s_axi_araddr == `DRSC_OFF_ROLE_CFG) begin
          s_axi_rdata <= {29'h0, role_cfg};
        end else if (plain_index(s_axi_araddr) != 4'hF) begin
          s_axi_rdata <= plain_regs[plain_index(s_axi_araddr)];
        end else begin
          s_axi_rdata <= `DRSC_ZERO;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : drsc_session_ctrl

// File: tb/drsc_checker.sv
// assertions on the bus and role ports of the session control block
`timescale 1ns/1ps
module drsc_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // role and request levels
  input wire logic session_req,
  input wire logic host_mode,
  input wire logic low_speed
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // the two halves of a write handshake
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  write_answer_a: assert property (
    aw_taken ##0 w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  slverr_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  awready_pulse_a: assert property (
    s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
  arready_soon_a: assert property (
    s_axi_arvalid && !s_axi_arready |-> ##[1:2] s_axi_arready)
    else $error("read address not taken");
  speed_role_a: assert property (
    low_speed |-> host_mode)
    else $error("low speed outside host role");
  req_by_write_a: assert property (
    $rose(session_req) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("session request rose without a write");
endmodule : drsc_checker

// File: tb/drsc_peer_model.sv
// cable peer that grants session requests, and role swap requests made while dev_side_swap_en is set, after a delay
`timescale 1ns/1ps
module drsc_peer_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // requests from the block
  input wire logic session_req,
  input wire logic role_swap_req,
  input wire logic dev_side_swap_en,
  // peer answers
  output logic session_req_ok_in,
  output logic role_swap_ok_in,
  output logic b_session_valid_in
);
  logic [7:0] sess_line;
  logic [7:0] swap_line;
  // answers trail each request by LAT+1 cycles and drop once it is withdrawn
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sess_line <= 8'h00;
      swap_line <= 8'h00;
    end else begin
      sess_line <= {sess_line[6:0], session_req};
      swap_line <= {swap_line[6:0], role_swap_req & dev_side_swap_en};
    end
  end
  // session validity follows the granted session
  assign session_req_ok_in = sess_line[LAT];
  assign b_session_valid_in = sess_line[LAT];
  assign role_swap_ok_in = swap_line[LAT];
endmodule : drsc_peer_model

// File: tb/testbench.sv
// register level test of the session control block
`timescale 1ns/1ps
`include "drsc_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module testbench;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic session_req_ok_in, role_swap_ok_in, connector_id_in, debounce_short_in;
  logic a_session_valid_in, b_session_valid_in, session_req, role_swap_req;
  logic host_side_swap_en, dev_side_swap_en, host_mode, low_speed, irq;
  logic [11:0] plain [12] = '{12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h024,
    12'h028, 12'h038, 12'h100, 12'h104, 12'h108, 12'h10C};
  int fails, check_count;
  drsc_session_ctrl dut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .session_req_ok_in, .role_swap_ok_in, .connector_id_in,
    .debounce_short_in, .a_session_valid_in, .b_session_valid_in, .session_req,
    .role_swap_req, .host_side_swap_en, .dev_side_swap_en, .host_mode, .low_speed, .irq);
  drsc_peer_model peer (.clk_sys, .rst_n, .session_req, .role_swap_req, .dev_side_swap_en,
    .session_req_ok_in, .role_swap_ok_in, .b_session_valid_in);
  // one write: both channels offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rr);
    int n;
    bit pa, pw;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pa = 1;
    pw = 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (pa && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        pa = 0;
      end
      if (pw && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        pw = 0;
      end
    end while ((pa || pw) && n < 50);
    while (!s_axi_bvalid && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // one read: address until taken, then accept the data
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // write expecting an okay answer, then let the effect land
  task automatic wrok(input logic [11:0] a, input logic [31:0] v);
    wr(a, v, r);
    `CHK(r, `DRSC_RESP_OKAY)
    repeat (2) @(posedge clk_sys);
  endtask : wrok
  // read expecting a given word with an okay answer
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, `DRSC_RESP_OKAY)
  endtask : rchk
  task automatic print_verdict;
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end
  // main sequence
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h000000, 32'h0, 4'hF};
    {connector_id_in, debounce_short_in, a_session_valid_in} = 3'h4;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rchk(`DRSC_OFF_CTRL_STS, `DRSC_RST_CTRL_STS);
    `CHK(host_mode, 1'b0)
    wrok(`DRSC_OFF_EVT_MASK, 32'h0000_0300);
    repeat (4) @(posedge clk_sys); // bus discharge pause before a request
    wrok(12'h000, 32'h0000_0A02);
    `CHK({session_req, role_swap_req, dev_side_swap_en}, 3'h7)
    repeat (12) @(posedge clk_sys);
    rchk(12'h000, 32'h0009_0B03);
    rchk(12'h004, 32'h0000_0300);
    `CHK(irq, 1'b1)
    wrok(12'h004, 32'h0000_0100);
    `CHK({session_req, role_swap_req}, 2'h1)
    repeat (12) @(posedge clk_sys);
    rchk(12'h000, 32'h0001_0B00);
    rchk(12'h004, 32'h0000_0300);
    wrok(12'h004, 32'h0000_0300);
    `CHK(role_swap_req, 1'b0)
    repeat (12) @(posedge clk_sys);
    rchk(12'h004, 32'h0000_0200);
    `CHK(irq, 1'b1)
    wrok(`DRSC_OFF_EVT_MASK, 32'h0);
    `CHK(irq, 1'b0)
    wrok(12'h004, 32'h0000_0200);
    wrok(12'h000, 32'hFFFF_F0F1);
    rchk(12'h000, `DRSC_RST_CTRL_STS);
    `CHK(dev_side_swap_en, 1'b0)
    rd(12'h030, d, r);
    `CHK({r, d}, {`DRSC_RESP_SLVERR, 32'h0})
    wr(12'h034, 32'h1234_5678, r);
    `CHK(r, `DRSC_RESP_SLVERR)
    foreach (plain[i]) begin
      wrok(plain[i], {20'hA5A5A, plain[i]});
      rchk(plain[i], {20'hA5A5A, plain[i]});
    end
    rchk(12'h03C, 32'h0);
    {connector_id_in, debounce_short_in, a_session_valid_in} <= 3'h3;
    repeat (4) @(posedge clk_sys);
    `CHK(host_mode, 1'b1)
    wrok(12'h000, 32'h0000_0400);
    rchk(12'h000, 32'h0006_0400);
    `CHK(host_side_swap_en, 1'b1)
    wrok(`DRSC_OFF_ROLE_CFG, 32'h4);
    `CHK(low_speed, 1'b1)
    wrok(`DRSC_OFF_ROLE_CFG, 32'h2);
    `CHK({host_mode, low_speed}, 2'h0)
    print_verdict();
  end
endmodule : testbench
bind drsc_session_ctrl drsc_checker chk (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .session_req, .host_mode,
  .low_speed);
